// [dv/aam_parser_model.sv]
// Frame parser model for the matcher
`timescale 1ns/1ns
module aam_parser_model (
  input  wire logic                aclk,
  input  wire logic                send,
  input  wire aam_pkg::aam_frame_t hdr,
  output logic                     frame_valid,
  output aam_pkg::aam_frame_t      frame
);
  import aam_pkg::*;
  // ==========
  // Handover; idle fields show the inverse of the header so a stale one never looks current
  always @(posedge aclk) {frame_valid, frame} <= {send, send ? hdr : ~hdr};
endmodule // aam_parser_model

// [dv/test_aam_matcher.sv]
// Testbench: random entries and frames against a reference model
`timescale 1ns/1ns
module test_aam_matcher;
  import aam_pkg::*;
  // ==========
  // Signals and instances
  logic        aclk = 1'h0, aresetn, send, match_valid, match_hit, lst, exp_q[$];
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, frame_valid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, c[7], d, hits;
  logic [47:0] m;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  aam_frame_t  hdr, frame, f;
  int          n_errors, checked, seed, i, k;
  always #5 aclk = ~aclk;
  aam_matcher DUT (.*);
  aam_parser_model u_parser (.*);
  task automatic chk(logic [31:0] got, logic [31:0] want);
    checked++;
    if (got !== want) $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    n_errors += int'(got !== want);
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic pk(logic [1:0] s, logic [3:0] v); return v[s]; endfunction
  function automatic logic t3(logic [1:0] s, logic x); return pk(s, {1'h1, x, !x, 1'h1}); endfunction
  function automatic logic ref_hit(aam_frame_t g);
    logic a, q;
    a = g.opcode_field inside {OP_ARP_REQ, OP_ARP_REP};
    q = g.opcode_field inside {OP_RARP_REQ, OP_RARP_REP};
    if (c[0][0]) return c[0][1] && g.is_icmp && (!c[6][0] || g.icmp_type == c[6][15:8])
      && (!c[6][1] || g.icmp_code == c[6][23:16]);
    return c[0][1] && g.is_arp && pk(c[1][1:0], {!a && !q, q, a, 1'h1})
      && pk(c[1][3:2], {1'h1, (a || q) && !g.opcode_field[0], (a || q) && g.opcode_field[0], 1'h1})
      && pk(c[1][5:4], {1'h1, ((g.sender_protocol_address ^ c[2]) & c[3]) == '0,
                        g.sender_protocol_address == c[2], 1'h1})
      && pk(c[1][7:6], {1'h1, ((g.target_protocol_address ^ c[4]) & c[5]) == '0,
                        g.target_protocol_address == c[4], 1'h1})
      && (!a || t3(c[1][9:8], g.sender_hw_addr == g.frame_source_mac))
      && (!q || t3(c[1][11:10], g.target_hw_addr == g.frame_source_mac))
      && t3(c[1][13:12], g.hw_len == HLN_ETH && g.proto_len == PLN_IPV4)
      && t3(c[1][15:14], g.hw_type == HRD_ETH) && t3(c[1][17:16], g.proto_type == PRO_IP);
  endfunction
  // verdict against the oldest one owed
  always @(posedge aclk) if (aresetn && match_valid === 1'h1) chk(match_hit, exp_q.pop_front());
  // Bus cycle; each channel is released at the edge that takes it, readies are set per call
  task automatic bus(logic w, logic [7:0] a, logic [31:0] v, logic [1:0] e);
    int n;
    if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_rready} <= {a, v, 4'hE};
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready, s_axi_bready} <= {a, 3'h6};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
      if (w ? s_axi_bvalid : s_axi_rvalid) break;
    end
    if (n == 50) n_errors++;
    if (n == 50) summarize();
    chk(w ? s_axi_bresp : s_axi_rresp, e);
    if (!w) chk(s_axi_rdata, v);
  endtask
  // ==========
  // Sequence
  initial begin
    seed = 95;
    hits = 32'h0;
    {aresetn, send, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, hdr} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (i = 0; i < 10; i++) bus(0, 8'(4 * i), REG_RESET, i == 9 ? RESP_SLVERR : RESP_OKAY);
    // Byte-lane write: only lane 1 may land
    s_axi_wstrb <= 4'h2;
    bus(1, AAM_ADDR_SADDR, 32'hA5A5_A5A5, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    bus(0, AAM_ADDR_SADDR, 32'h0000_A500, RESP_OKAY);
    for (k = 0; k < 200; k++) begin
      // Sparse selectors give hits a chance; every eighth entry is disabled
      for (i = 0; i < 7; i++) begin
        c[i] = $random(seed);
        if (i == 1) c[i] &= $random(seed);
        if (i == 0) c[i][1] = k % 8 != 0;
        if (i == 3 || i == 5) c[i][7:0] = 8'h00;
        bus(1, 8'(4 * i), c[i], RESP_OKAY);
      end
      bus(0, AAM_ADDR_SADDR, c[2], RESP_OKAY);
      for (i = 0; i < 3; i++) begin
        d = $random(seed);
        m = {d[15:0], $random(seed)};
        f = '{d[0], d[1], m, d[2] ? HRD_ETH : 16'h0006, d[3] ? PRO_IP : 16'h86DD, d[4] ? HLN_ETH : 8'h10,
              d[5] ? PLN_IPV4 : 8'h10, {13'h0, d[8:6]}, d[9] ? m : ~m, c[2] ^ {24'h0, d[11] ? 8'h00 : d[23:16]},
              d[10] ? m : m ^ 48'h1, c[4] ^ {24'h0, d[12] ? 8'h00 : d[31:24]},
              d[13] ? c[6][15:8] : d[23:16], d[14] ? c[6][23:16] : d[31:24]};
        lst = ref_hit(f);
        exp_q.push_back(lst);
        hits += 32'(lst);
        {hdr, send} <= {f, 1'h1};
        @(posedge aclk);
      end
      send <= 1'h0;
      repeat (3) @(posedge aclk);
    end
    bus(0, AAM_ADDR_STATUS, {31'h0, lst}, RESP_OKAY);
    bus(1, AAM_ADDR_HITS, 32'h0, RESP_OKAY);
    bus(0, AAM_ADDR_HITS, hits, RESP_OKAY);
    bus(1, 8'h24, 32'hFFFF_FFFF, RESP_SLVERR);
    summarize();
  end
endmodule // test_aam_matcher

// [hdl/aam_addr_filter.sv]
// Protocol address filter: don't-care, host or masked network compare
`timescale 1ns/1ns
module aam_addr_filter #(
  parameter int unsigned AW = 32                            // Address width
) (
  input  wire logic [1:0]    mode,                          // Filter selector
  input  wire logic [AW-1:0] addr,                          // Address from the frame
  input  wire logic [AW-1:0] ref_addr,                      // Configured address
  input  wire logic [AW-1:0] ref_mask,                      // Configured mask
  output logic               ok                             // Frame passes
);
  import aam_pkg::*;

  // ==========================================================================
  // Compare terms
  logic host_eq;                                            // Exact equality
  logic net_eq;                                             // Equality under mask

  assign host_eq = (addr == ref_addr);
  // Both sides masked, so stray host bits in the configured value are harmless
  assign net_eq  = ((addr & ref_mask) == (ref_addr & ref_mask));

  // Reserved code falls back to don't-care rather than blocking everything
  assign ok = (mode == FLT_HOST)    ? host_eq :
              (mode == FLT_NETWORK) ? net_eq  : 1'b1;

endmodule // aam_addr_filter

// [hdl/aam_matcher.sv]
// ARP/RARP and ICMP access control entry matcher with AXI4-Lite configuration
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
// Operation
// R1: Opcode class any, ARP, RARP or other
// R2: Request/reply selects request or reply opcodes
// R3: Sender address any, host or network
// R4: Target address any, host or network
// R5: ARP sender hardware versus source MAC
// R6: RARP target hardware versus source MAC
// R7: Lengths six and four, tri-state
// R8: Hardware type one, tri-state
// R9: Protocol type 0x800, tri-state
// R10: ICMP type any or specific value
// R11: ICMP code any or specific value
// R12: Match is AND of all criteria
module aam_matcher (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [aam_pkg::AAM_AW-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [aam_pkg::AAM_AW-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    frame_valid,
  input  wire aam_pkg::aam_frame_t     frame,
  output logic                         match_valid,
  output logic                         match_hit
);
  import aam_pkg::*;

  // ==========================================================================
  // Byte-lane merge for partial writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Tri-state selector: must be false, must be true, or don't-care
  function automatic logic tri_ok(input logic [1:0] sel, input logic cond);
    return (sel == TRI_ONE) ? cond : (sel == TRI_ZERO) ? !cond : 1'b1;
  endfunction

  // ==========================================================================
  // Register and handshake state
  logic [AAM_AW-1:0] awaddr_q;                              // Held write address
  logic              aw_got_q;                              // Write address taken
  logic              w_got_q;                               // Write data taken
  logic [31:0]       wdata_q;                               // Held write data
  logic [3:0]        wstrb_q;                               // Held byte enables
  logic              bvalid_q;                              // Write response pending
  logic [1:0]        bresp_q;
  logic              rvalid_q;                              // Read response pending
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic [31:0]       ctrl_q;                                // Entry kind and enable
  logic [31:0]       arpcfg_q;                              // ARP/RARP selectors
  logic [31:0]       saddr_q;
  logic [31:0]       smask_q;
  logic [31:0]       taddr_q;
  logic [31:0]       tmask_q;
  logic [31:0]       icmpcfg_q;                             // ICMP selectors and values
  logic [31:0]       hits_q;                                // Matches seen since reset
  logic              match_valid_q;
  logic              match_hit_q;

  // ==========================================================================
  // AXI4-Lite handshake decode
  logic aw_take;                                            // Address beat this edge
  logic w_take;                                             // Data beat this edge
  logic do_write;                                           // Both halves present
  logic ar_take;                                            // Read address beat

  // A new beat is refused while the previous response is still owed
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign do_write      = aw_got_q && w_got_q && !bvalid_q;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  // Write address map: status and counter are mapped but ignore writes
  logic wr_ctrl, wr_arp, wr_sa, wr_sm, wr_ta, wr_tm, wr_icmp, wr_mapped;
  assign wr_ctrl   = do_write && (awaddr_q == AAM_ADDR_CTRL);
  assign wr_arp    = do_write && (awaddr_q == AAM_ADDR_ARPCFG);
  assign wr_sa     = do_write && (awaddr_q == AAM_ADDR_SADDR);
  assign wr_sm     = do_write && (awaddr_q == AAM_ADDR_SMASK);
  assign wr_ta     = do_write && (awaddr_q == AAM_ADDR_TADDR);
  assign wr_tm     = do_write && (awaddr_q == AAM_ADDR_TMASK);
  assign wr_icmp   = do_write && (awaddr_q == AAM_ADDR_ICMPCFG);
  assign wr_mapped = wr_ctrl || wr_arp || wr_sa || wr_sm || wr_ta || wr_tm || wr_icmp ||
                     (awaddr_q == AAM_ADDR_STATUS) || (awaddr_q == AAM_ADDR_HITS);

  // Read mux; unmapped addresses answer zero with an error response
  logic [31:0] rd_mux;
  logic        rd_hit;
  assign rd_hit = (s_axi_araddr == AAM_ADDR_CTRL)   || (s_axi_araddr == AAM_ADDR_ARPCFG) ||
                  (s_axi_araddr == AAM_ADDR_SADDR)  || (s_axi_araddr == AAM_ADDR_SMASK)  ||
                  (s_axi_araddr == AAM_ADDR_TADDR)  || (s_axi_araddr == AAM_ADDR_TMASK)  ||
                  (s_axi_araddr == AAM_ADDR_ICMPCFG) || (s_axi_araddr == AAM_ADDR_STATUS) ||
                  (s_axi_araddr == AAM_ADDR_HITS);
  assign rd_mux = (s_axi_araddr == AAM_ADDR_CTRL)    ? ctrl_q    :
                  (s_axi_araddr == AAM_ADDR_ARPCFG)  ? arpcfg_q  :
                  (s_axi_araddr == AAM_ADDR_SADDR)   ? saddr_q   :
                  (s_axi_araddr == AAM_ADDR_SMASK)   ? smask_q   :
                  (s_axi_araddr == AAM_ADDR_TADDR)   ? taddr_q   :
                  (s_axi_araddr == AAM_ADDR_TMASK)   ? tmask_q   :
                  (s_axi_araddr == AAM_ADDR_ICMPCFG) ? icmpcfg_q :
                  (s_axi_araddr == AAM_ADDR_STATUS)  ? {30'h0000_0000, match_valid_q, match_hit_q} :
                  (s_axi_araddr == AAM_ADDR_HITS)    ? hits_q    : 32'h0000_0000;

  // ==========================================================================
  // Write channel: address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= REG_RESET;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address beat to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= REG_RESET;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // Configuration registers; unused control bits are kept at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= REG_RESET;
      arpcfg_q  <= REG_RESET;
      saddr_q   <= REG_RESET;
      smask_q   <= REG_RESET;
      taddr_q   <= REG_RESET;
      tmask_q   <= REG_RESET;
      icmpcfg_q <= REG_RESET;
    end else begin
      if (wr_ctrl) ctrl_q <= wmerge(ctrl_q, wdata_q, wstrb_q) & CTRL_USED;
      if (wr_arp) arpcfg_q <= wmerge(arpcfg_q, wdata_q, wstrb_q) & ARPCFG_USED;
      if (wr_sa) saddr_q <= wmerge(saddr_q, wdata_q, wstrb_q);
      if (wr_sm) smask_q <= wmerge(smask_q, wdata_q, wstrb_q);
      if (wr_ta) taddr_q <= wmerge(taddr_q, wdata_q, wstrb_q);
      if (wr_tm) tmask_q <= wmerge(tmask_q, wdata_q, wstrb_q);
      if (wr_icmp) icmpcfg_q <= wmerge(icmpcfg_q, wdata_q, wstrb_q) & ICMPCFG_USED;
    end
  end

  // ==========================================================================
  // Configuration fields
  logic       kind_icmp, entry_en, type_spec, code_spec;
  logic [1:0] sel_opc, sel_rr, sel_sf, sel_tf, sel_sha, sel_tha, sel_len, sel_hrd, sel_pro;
  logic [7:0] cfg_type, cfg_code;
  assign kind_icmp = ctrl_q[CTRL_KIND_BIT];
  assign entry_en  = ctrl_q[CTRL_EN_BIT];
  assign sel_opc   = arpcfg_q[ARP_OPCLASS_LSB +: 2];
  assign sel_rr    = arpcfg_q[ARP_REQREP_LSB +: 2];
  assign sel_sf    = arpcfg_q[ARP_SFILT_LSB +: 2];
  assign sel_tf    = arpcfg_q[ARP_TFILT_LSB +: 2];
  assign sel_sha   = arpcfg_q[ARP_SHAM_LSB +: 2];
  assign sel_tha   = arpcfg_q[ARP_THAM_LSB +: 2];
  assign sel_len   = arpcfg_q[ARP_LEN_LSB +: 2];
  assign sel_hrd   = arpcfg_q[ARP_HRD_LSB +: 2];
  assign sel_pro   = arpcfg_q[ARP_PRO_LSB +: 2];
  assign type_spec = icmpcfg_q[ICMP_TSPEC_BIT];
  assign code_spec = icmpcfg_q[ICMP_CSPEC_BIT];
  assign cfg_type  = icmpcfg_q[ICMP_TYPE_LSB +: 8];
  assign cfg_code  = icmpcfg_q[ICMP_CODE_LSB +: 8];

  // ==========================================================================
  // Per-criterion verdicts
  logic is_arp_op, is_rarp_op, is_req, is_rep;
  logic opc_ok, rr_ok, sha_ok, tha_ok, len_ok, hrd_ok, pro_ok, type_ok, code_ok;
  logic arp_all, icmp_all, hit_now;
  logic [1:0] addr_ok;                                      // Sender, target filters

  assign is_arp_op  = (frame.opcode_field == OP_ARP_REQ) || (frame.opcode_field == OP_ARP_REP);
  assign is_rarp_op = (frame.opcode_field == OP_RARP_REQ) || (frame.opcode_field == OP_RARP_REP);
  assign is_req     = (frame.opcode_field == OP_ARP_REQ) || (frame.opcode_field == OP_RARP_REQ);
  assign is_rep     = (frame.opcode_field == OP_ARP_REP) || (frame.opcode_field == OP_RARP_REP);

  // R1: opcode class select
  assign opc_ok = (sel_opc == OPC_ARP)   ? is_arp_op  :
                  (sel_opc == OPC_RARP)  ? is_rarp_op :
                  (sel_opc == OPC_OTHER) ? (!is_arp_op && !is_rarp_op) : 1'b1;
  // R2: request or reply opcodes
  assign rr_ok  = (sel_rr == RR_REQUEST) ? is_req : (sel_rr == RR_REPLY) ? is_rep : 1'b1;

  // R3: sender address filter; R4: target address filter
  for (genvar g = 0; g < 2; g++) begin : g_addr
    aam_addr_filter #(.AW(32)) u_flt (
      .mode    (g == 0 ? sel_sf : sel_tf),
      .addr    (g == 0 ? frame.sender_protocol_address : frame.target_protocol_address),
      .ref_addr(g == 0 ? saddr_q : taddr_q),
      .ref_mask(g == 0 ? smask_q : tmask_q),
      .ok      (addr_ok[g])
    );
  end

  // R5: hardware compare only judges ARP opcodes
  assign sha_ok = !is_arp_op || tri_ok(sel_sha, frame.sender_hw_addr == frame.frame_source_mac);
  // R6: hardware compare only judges RARP opcodes
  assign tha_ok = !is_rarp_op || tri_ok(sel_tha, frame.target_hw_addr == frame.frame_source_mac);
  // R7: Ethernet and IPv4 address lengths
  assign len_ok = tri_ok(sel_len, (frame.hw_len == HLN_ETH) && (frame.proto_len == PLN_IPV4));
  // R8: hardware space test
  assign hrd_ok = tri_ok(sel_hrd, frame.hw_type == HRD_ETH);
  // R9: protocol space test
  assign pro_ok = tri_ok(sel_pro, frame.proto_type == PRO_IP);
  // R10: ICMP type value
  assign type_ok = !type_spec || (frame.icmp_type == cfg_type);
  // R11: ICMP code value
  assign code_ok = !code_spec || (frame.icmp_code == cfg_code);

  // R12: AND of every criterion for the entry kind
  assign arp_all  = frame.is_arp && opc_ok && rr_ok && (&addr_ok) && sha_ok && tha_ok &&
                    len_ok && hrd_ok && pro_ok;
  assign icmp_all = frame.is_icmp && type_ok && code_ok;
  assign hit_now  = entry_en && (kind_icmp ? icmp_all : arp_all);

  // ==========================================================================
  // Registered verdict, one cycle after the frame strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_valid_q <= 1'b0;
      match_hit_q   <= 1'b0;
      hits_q        <= REG_RESET;
    end else begin
      match_valid_q <= frame_valid;
      if (frame_valid) begin
        match_hit_q <= hit_now;
      end
      // Counter wraps; software takes differences
      if (frame_valid && hit_now) begin
        hits_q <= hits_q + 32'h0000_0001;
      end
    end
  end

  assign match_valid = match_valid_q;
  assign match_hit   = match_hit_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_opclass_arp: assert property ( // R1
    frame_valid && !kind_icmp && sel_opc == OPC_ARP && !is_arp_op |=> !match_hit)
    else $error("ARP class matched a non-ARP opcode");
  a_reqrep_sel: assert property ( // R2
    frame_valid && !kind_icmp && sel_rr == RR_REPLY && is_req |=> match_valid && !match_hit)
    else $error("Reply selector matched a request");
  a_sender_host: assert property ( // R3
    frame_valid && !kind_icmp && sel_sf == FLT_HOST && frame.sender_protocol_address != saddr_q
    |=> !match_hit)
    else $error("Sender host filter passed a different address");
  a_target_net: assert property ( // R4
    frame_valid && !kind_icmp && sel_tf == FLT_NETWORK &&
    ((frame.target_protocol_address ^ taddr_q) & tmask_q) != 32'h0000_0000 |=> !match_hit)
    else $error("Target network filter passed outside the mask");
  a_arp_hwmatch: assert property ( // R5
    frame_valid && !kind_icmp && is_arp_op && sel_sha == TRI_ZERO &&
    frame.sender_hw_addr == frame.frame_source_mac |=> !match_hit)
    else $error("ARP hardware compare ignored");
  a_rarp_hwmatch: assert property ( // R6
    frame_valid && !kind_icmp && is_rarp_op && sel_tha == TRI_ONE &&
    frame.target_hw_addr != frame.frame_source_mac |=> !match_hit)
    else $error("RARP hardware compare ignored");
  a_len_test: assert property ( // R7
    frame_valid && !kind_icmp && sel_len == TRI_ONE && frame.hw_len != HLN_ETH |=> !match_hit)
    else $error("Length test passed a wrong length");
  a_hwspace_test: assert property ( // R8
    frame_valid && !kind_icmp && sel_hrd == TRI_ZERO && frame.hw_type == HRD_ETH |=> !match_hit)
    else $error("Hardware space zero setting passed type one");
  a_proto_space: assert property ( // R9
    frame_valid && !kind_icmp && sel_pro == TRI_ONE && frame.proto_type != PRO_IP |=> !match_hit)
    else $error("Protocol space test passed a wrong type");
  a_icmp_type: assert property ( // R10
    frame_valid && kind_icmp && type_spec && frame.icmp_type != cfg_type |=> !match_hit)
    else $error("ICMP type mismatch matched");
  a_icmp_code: assert property ( // R11
    frame_valid && kind_icmp && code_spec && frame.icmp_code != cfg_code |=> !match_hit)
    else $error("ICMP code mismatch matched");
  a_match_and: assert property ( // R12
    match_valid |-> match_hit == $past(entry_en && (kind_icmp ? icmp_all : arp_all)))
    else $error("Verdict differs from the AND of criteria");

endmodule // aam_matcher

// [hdl/aam_pkg.sv]
// Package: register map, field layout, protocol constants and carriers of the matcher
package aam_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam int unsigned AAM_AW = 8;                       // Register address width
  localparam logic [7:0] AAM_ADDR_CTRL    = 8'h00;          // Kind and enable
  localparam logic [7:0] AAM_ADDR_ARPCFG  = 8'h04;          // ARP/RARP selectors
  localparam logic [7:0] AAM_ADDR_SADDR   = 8'h08;          // Sender address
  localparam logic [7:0] AAM_ADDR_SMASK   = 8'h0C;          // Sender mask
  localparam logic [7:0] AAM_ADDR_TADDR   = 8'h10;          // Target address
  localparam logic [7:0] AAM_ADDR_TMASK   = 8'h14;          // Target mask
  localparam logic [7:0] AAM_ADDR_ICMPCFG = 8'h18;          // ICMP selectors and values
  localparam logic [7:0] AAM_ADDR_STATUS  = 8'h1C;          // Last verdict, read only
  localparam logic [7:0] AAM_ADDR_HITS    = 8'h20;          // Match counter, read only

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_KIND_BIT   = 0;              // 0 ARP entry, 1 ICMP entry
  localparam int unsigned CTRL_EN_BIT     = 1;              // Entry enable
  localparam int unsigned ARP_OPCLASS_LSB = 0;
  localparam int unsigned ARP_REQREP_LSB  = 2;
  localparam int unsigned ARP_SFILT_LSB   = 4;
  localparam int unsigned ARP_TFILT_LSB   = 6;
  localparam int unsigned ARP_SHAM_LSB    = 8;
  localparam int unsigned ARP_THAM_LSB    = 10;
  localparam int unsigned ARP_LEN_LSB     = 12;
  localparam int unsigned ARP_HRD_LSB     = 14;
  localparam int unsigned ARP_PRO_LSB     = 16;
  localparam int unsigned ICMP_TSPEC_BIT  = 0;
  localparam int unsigned ICMP_CSPEC_BIT  = 1;
  localparam int unsigned ICMP_TYPE_LSB   = 8;
  localparam int unsigned ICMP_CODE_LSB   = 16;

  // ==========================================================================
  // Selector encodings and reset values
  localparam logic [1:0] SEL_ANY      = 2'h0;               // Don't-care in every selector
  localparam logic [1:0] OPC_ARP      = 2'h1;
  localparam logic [1:0] OPC_RARP     = 2'h2;
  localparam logic [1:0] OPC_OTHER    = 2'h3;
  localparam logic [1:0] RR_REQUEST   = 2'h1;
  localparam logic [1:0] RR_REPLY     = 2'h2;
  localparam logic [1:0] FLT_HOST     = 2'h1;
  localparam logic [1:0] FLT_NETWORK  = 2'h2;
  localparam logic [1:0] TRI_ZERO     = 2'h1;               // Condition must be false
  localparam logic [1:0] TRI_ONE      = 2'h2;               // Condition must be true
  localparam logic [31:0] REG_RESET   = 32'h0000_0000;
  // Implemented bits; the rest stay zero so software reads back what the logic uses
  localparam logic [31:0] CTRL_USED    = 32'h0000_0003;     // Kind and enable
  localparam logic [31:0] ARPCFG_USED  = 32'h0003_FFFF;     // Nine 2-bit selectors
  localparam logic [31:0] ICMPCFG_USED = 32'h00FF_FF03;     // Two flags, type, code

  // ==========================================================================
  // Protocol constants
  localparam logic [15:0] OP_ARP_REQ  = 16'h0001;
  localparam logic [15:0] OP_ARP_REP  = 16'h0002;
  localparam logic [15:0] OP_RARP_REQ = 16'h0003;
  localparam logic [15:0] OP_RARP_REP = 16'h0004;
  localparam logic [7:0]  HLN_ETH     = 8'h06;
  localparam logic [7:0]  PLN_IPV4    = 8'h04;
  localparam logic [15:0] HRD_ETH     = 16'h0001;
  localparam logic [15:0] PRO_IP      = 16'h0800;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Parsed header fields handed over by the frame parser
  typedef struct packed {
    logic        is_arp;                                    // ARP/RARP ethertype seen
    logic        is_icmp;                                   // IPv4 ICMP frame seen
    logic [47:0] frame_source_mac;
    logic [15:0] hw_type;
    logic [15:0] proto_type;
    logic [7:0]  hw_len;
    logic [7:0]  proto_len;
    logic [15:0] opcode_field;
    logic [47:0] sender_hw_addr;
    logic [31:0] sender_protocol_address;
    logic [47:0] target_hw_addr;
    logic [31:0] target_protocol_address;
    logic [7:0]  icmp_type;
    logic [7:0]  icmp_code;
  } aam_frame_t;

endpackage
